/* rtl/bbl_ctrl.sv */
// blanking timers, extension counter and burst level detection
`timescale 1ns/1ns
module bbl_ctrl #(
   parameter int unsigned BLANK_CYC = bbl_pkg::BLANK_CYC,
   parameter int unsigned DET_CYC   = bbl_pkg::DET_CYC
) (
   input  wire logic                        mclk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        ce_i,
   input  wire logic                        gate_on_i,
   input  wire logic                        cs_cmp_i,
   output logic                             cs_trip_o,
   output logic [bbl_pkg::TRIM_W-1:0]       csth_trim_o,
   output logic                             csth_burst_o,
   input  wire logic                        fb_above_4v5_i,
   input  wire logic                        fb_below_entry_i,
   input  wire logic                        burst_exit_i,
   input  wire logic                        wake_cmp_i,
   input  wire logic                        sleep_cmp_i,
   output logic                             burst_mode_o,
   output logic                             bias_on_o,
   input  wire logic                        extend_mode_i,
   input  wire logic                        upper_threshold_cmp_i,
   input  wire logic                        lower_threshold_cmp_i,
   output logic                             charge_switch_o,
   output logic                             discharge_switch_o,
   output logic                             extend_done_o,
   output logic                             auto_restart_o,
   input  wire logic                        supply_ok_i,
   input  wire logic                        protect_active_i,
   input  wire logic                        fb_det_high_i,
   input  wire logic                        fb_det_low_i,
   output logic                             detect_flipflop_o,
   output logic                             detect_discharge_switch_o,
   output bbl_pkg::bbl_level_e              burst_level_o,
   output logic                             level_valid_o
);
   bbl_pkg::bbl_main_s r;
   bbl_pkg::bbl_main_s next_r;
   logic                     ext_en;
   logic                     ext_full;
   logic                     det_en;
   logic                     det_clr;
   logic [bbl_pkg::OSC_W-1:0] det_count;
   logic                     gate_rise;

   // last cycle of a window of lim cycles
   function automatic logic cnt_hit(input logic [bbl_pkg::CNT_W-1:0] cnt,
                                    input int unsigned lim);
      return cnt == bbl_pkg::CNT_W'(lim - 1);
   endfunction : cnt_hit

   // fewer oscillations in the window mean a larger feedback capacitor
   function automatic bbl_pkg::bbl_level_e count_to_level(
      input logic [bbl_pkg::OSC_W-1:0] cnt);
      if (cnt < bbl_pkg::OSC_W'(bbl_pkg::DET_BND_HI)) begin
         return bbl_pkg::LVL_1V60;
      end else if (cnt < bbl_pkg::OSC_W'(bbl_pkg::DET_BND_MID)) begin
         return bbl_pkg::LVL_1V42;
      end else if (cnt < bbl_pkg::OSC_W'(bbl_pkg::DET_BND_LO)) begin
         return bbl_pkg::LVL_1V27;
      end else begin
         return bbl_pkg::LVL_NONE;
      end
   endfunction : count_to_level

   assign gate_rise = gate_on_i && !r.gate_q;
   // overload gone clears the extension counter at once
   assign ext_en  = (r.ol_st == bbl_pkg::OL_EXTEND) && fb_above_4v5_i;
   assign det_en  = (r.det_st == bbl_pkg::DET_RUN);
   assign det_clr = (r.det_st == bbl_pkg::DET_WAIT);

   bbl_osc_cnt u_ext_cnt (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .clr_i       (!fb_above_4v5_i),
      .en_i        (ext_en),
      .upper_i     (upper_threshold_cmp_i),
      .lower_i     (lower_threshold_cmp_i),
      .charge_o    (charge_switch_o),
      .discharge_o (discharge_switch_o),
      .count_o     (),
      .full_o      (ext_full)
   );

   // detection reuses the same relaxation counter; its charge path is the
   // feedback pull-up, so only the discharge switch leaves the block
   bbl_osc_cnt u_det_cnt (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .clr_i       (det_clr),
      .en_i        (det_en),
      .upper_i     (fb_det_high_i),
      .lower_i     (fb_det_low_i),
      .charge_o    (),
      .discharge_o (detect_discharge_switch_o),
      .count_o     (det_count),
      .full_o      ()
   );

   always_comb begin
      next_r        = r;
      next_r.gate_q = gate_on_i;

      // leading edge blanking and on-time for the dynamic threshold
      if (gate_rise) begin
         next_r.leb_cnt = r.burst ? 4'(bbl_pkg::LEB_BURST_CYC)
                                  : 4'(bbl_pkg::LEB_NORM_CYC);
         next_r.ontime  = '0;
      end else if (r.leb_cnt != 4'h0) begin
         next_r.leb_cnt = r.leb_cnt - 4'h1;
      end
      if (gate_on_i && !gate_rise && (r.ontime != '1)) begin
         // short on-time to the trip point means a steep slope
         next_r.ontime = r.ontime + 1'b1;
      end
      next_r.cs_trip = gate_on_i && !gate_rise && (r.leb_cnt == 4'h0)
                       && cs_cmp_i;

      // burst entry blanking
      if (r.burst) begin
         next_r.bu_cnt = '0;
         if (burst_exit_i) begin
            next_r.burst   = 1'b0;
            next_r.bias_on = 1'b1;
         end else if (wake_cmp_i) begin
            next_r.bias_on = 1'b1;
         end else if (sleep_cmp_i) begin
            next_r.bias_on = 1'b0;
         end
      end else if (!fb_below_entry_i || (r.level == bbl_pkg::LVL_NONE)
                   || (r.det_st != bbl_pkg::DET_DONE)) begin
         next_r.bu_cnt = '0;
      end else if (cnt_hit(r.bu_cnt, BLANK_CYC)) begin
         next_r.bu_cnt  = '0;
         next_r.burst   = 1'b1;
         next_r.bias_on = 1'b0;
      end else begin
         next_r.bu_cnt = r.bu_cnt + 1'b1;
      end

      // overload blanking, extension and spike blanking
      case (r.ol_st)
         bbl_pkg::OL_IDLE: begin
            next_r.ol_cnt = '0;
            if (fb_above_4v5_i) begin
               next_r.ol_st = bbl_pkg::OL_BLANK;
            end
         end
         bbl_pkg::OL_BLANK: begin
            if (cnt_hit(r.ol_cnt, BLANK_CYC)) begin
               next_r.ol_cnt = '0;
               // extension only on this path, never for burst entry
               next_r.ol_st  = extend_mode_i ? bbl_pkg::OL_EXTEND
                                             : bbl_pkg::OL_SPIKE;
            end else begin
               next_r.ol_cnt = r.ol_cnt + 1'b1;
            end
         end
         bbl_pkg::OL_EXTEND: begin
            next_r.ol_cnt = '0;
            if (ext_full) begin
               next_r.ol_st = bbl_pkg::OL_SPIKE;
            end
         end
         bbl_pkg::OL_SPIKE: begin
            if (cnt_hit(r.ol_cnt, bbl_pkg::SPIKE_CYC)) begin
               next_r.ol_cnt       = '0;
               next_r.ol_st        = bbl_pkg::OL_RESTART;
               next_r.auto_restart = 1'b1;
            end else begin
               next_r.ol_cnt = r.ol_cnt + 1'b1;
            end
         end
         bbl_pkg::OL_RESTART: begin
            next_r.ol_cnt = '0;
            // the restart cycle ends with the supply lockout dropping
            if (!supply_ok_i) begin
               next_r.ol_st        = bbl_pkg::OL_IDLE;
               next_r.auto_restart = 1'b0;
            end
         end
         default: begin
            next_r.ol_st = bbl_pkg::OL_IDLE;
         end
      endcase
      if (!fb_above_4v5_i && (r.ol_st != bbl_pkg::OL_RESTART)) begin
         next_r.ol_st  = bbl_pkg::OL_IDLE;
         next_r.ol_cnt = '0;
      end

      // burst level detection, once per power-on
      case (r.det_st)
         bbl_pkg::DET_WAIT: begin
            next_r.det_cnt = '0;
            if (supply_ok_i && !protect_active_i) begin
               next_r.det_st = bbl_pkg::DET_RUN;
            end
         end
         bbl_pkg::DET_RUN: begin
            if (cnt_hit(r.det_cnt, DET_CYC)) begin
               next_r.det_st = bbl_pkg::DET_DONE;
            end else begin
               next_r.det_cnt = r.det_cnt + 1'b1;
            end
         end
         bbl_pkg::DET_DONE: begin
            // restarts never detect again
            next_r.det_cnt = '0;
         end
         default: begin
            next_r.det_st = bbl_pkg::DET_WAIT;
         end
      endcase
      if ((r.det_st == bbl_pkg::DET_RUN)
          && (next_r.det_st == bbl_pkg::DET_DONE)) begin
         next_r.level = count_to_level(det_count);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r         <= '0;
         r.ol_st   <= bbl_pkg::OL_IDLE;
         r.det_st  <= bbl_pkg::DET_WAIT;
         r.level   <= bbl_pkg::LVL_NONE;
         r.bias_on <= 1'b1;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign cs_trip_o         = r.cs_trip;
   assign csth_trim_o       = r.ontime;
   assign csth_burst_o      = r.burst && (r.level != bbl_pkg::LVL_NONE);
   assign burst_mode_o      = r.burst;
   assign bias_on_o         = r.bias_on;
   assign extend_done_o     = ext_full;
   assign auto_restart_o    = r.auto_restart;
   assign detect_flipflop_o = detect_discharge_switch_o;
   assign burst_level_o     = r.level;
   assign level_valid_o     = (r.det_st == bbl_pkg::DET_DONE);

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // last count of the spike window, declared before the checks use it
   localparam logic [bbl_pkg::CNT_W-1:0] CNT_SPIKE_LAST =
      bbl_pkg::CNT_W'(bbl_pkg::SPIKE_CYC - 1);

   sequence s_switch_on;
      ce_i && gate_on_i && !r.gate_q;
   endsequence
   sequence s_det_start;
      ce_i && (r.det_st == bbl_pkg::DET_WAIT) && supply_ok_i
      && !protect_active_i;
   endsequence

   chk_leb_hold_off: assert property (
      s_switch_on |=> !cs_trip_o [*8])
      else $error("sense trip inside leading edge blanking");
   chk_leb_burst_len: assert property (
      (s_switch_on and r.burst) |=> r.leb_cnt == 4'(bbl_pkg::LEB_BURST_CYC))
      else $error("burst blanking length wrong");
   chk_burst_count_zero: assert property (
      (ce_i && !r.burst && !fb_below_entry_i) |=> r.bu_cnt == '0)
      else $error("burst blanking counter not held at zero");
   chk_no_burst_level: assert property (
      (r.level == bbl_pkg::LVL_NONE) |-> !burst_mode_o)
      else $error("burst entered with no-burst level");
   chk_ol_clear_all: assert property (
      (ce_i && !fb_above_4v5_i && (r.ol_st != bbl_pkg::OL_RESTART))
      |=> (r.ol_st == bbl_pkg::OL_IDLE) && (r.ol_cnt == '0)
          && !charge_switch_o)
      else $error("overload state not cleared");
   chk_restart_spike: assert property (
      $rose(auto_restart_o) |-> ($past(r.ol_st) == bbl_pkg::OL_SPIKE)
      && ($past(r.ol_cnt) == CNT_SPIKE_LAST))
      else $error("auto-restart without full spike blanking");
   chk_ext_gate_block: assert property (
      (r.ol_st == bbl_pkg::OL_EXTEND && !ext_full) |-> !auto_restart_o)
      else $error("gate passed before extension count full");
   chk_det_begin: assert property (
      s_det_start |=> (r.det_st == bbl_pkg::DET_RUN) && (r.det_cnt == '0))
      else $error("detection did not start");
   chk_det_once: assert property (
      (r.det_st == bbl_pkg::DET_DONE) |=> (r.det_st == bbl_pkg::DET_DONE)
      && $stable(r.level))
      else $error("level detection repeated");
   chk_bias_wake: assert property (
      (ce_i && r.burst && !burst_exit_i && wake_cmp_i) |=> bias_on_o)
      else $error("bias not resumed at wake level");
endmodule : bbl_ctrl

/* shared/bbl_pkg.sv */
// constants, types and state carriers of the blanking and burst level block
package bbl_pkg;
   localparam int CLK_NS       = 20;
   localparam int LEB_NORM_NS  = 220;
   localparam int LEB_BURST_NS = 180;
   localparam int BLANK_MS     = 20;
   localparam int SPIKE_US     = 30;
   localparam int DET_MS       = 1;
   // least times round up to whole cycles
   localparam int LEB_NORM_CYC  = (LEB_NORM_NS + CLK_NS - 1) / CLK_NS;
   localparam int LEB_BURST_CYC = (LEB_BURST_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLANK_CYC     = (BLANK_MS * 1000000) / CLK_NS;
   localparam int SPIKE_CYC     = (SPIKE_US * 1000) / CLK_NS;
   localparam int DET_CYC       = (DET_MS * 1000000) / CLK_NS;
   localparam int EXT_FULL      = 256;
   // detection count boundaries, fewer oscillations mean a larger capacitor
   localparam int DET_BND_HI   = 8;
   localparam int DET_BND_MID  = 64;
   localparam int DET_BND_LO   = 256;
   localparam int CNT_W        = 20;
   localparam int OSC_W        = 9;
   localparam int TRIM_W       = 4;

   typedef enum logic [1:0] {LVL_1V60, LVL_1V42, LVL_1V27, LVL_NONE} bbl_level_e;
   typedef enum logic [2:0] {
      OL_IDLE, OL_BLANK, OL_EXTEND, OL_SPIKE, OL_RESTART
   } bbl_ol_e;
   typedef enum logic [1:0] {DET_WAIT, DET_RUN, DET_DONE} bbl_det_e;

   typedef struct packed {
      logic             charge;
      logic             discharge;
      logic [OSC_W-1:0] count;
   } bbl_osc_s;

   typedef struct packed {
      bbl_ol_e           ol_st;
      logic [CNT_W-1:0]  ol_cnt;
      logic [CNT_W-1:0]  bu_cnt;
      logic              burst;
      logic              bias_on;
      bbl_det_e          det_st;
      logic [CNT_W-1:0]  det_cnt;
      bbl_level_e        level;
      logic              gate_q;
      logic [3:0]        leb_cnt;
      logic [TRIM_W-1:0] ontime;
      logic              cs_trip;
      logic              auto_restart;
   } bbl_main_s;
endpackage : bbl_pkg

/* rtl/bbl_osc_cnt.sv */
// charge/discharge cycle counter for an external capacitor
`timescale 1ns/1ns
module bbl_osc_cnt (
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      ce_i,
   input  wire logic                      clr_i,
   input  wire logic                      en_i,
   input  wire logic                      upper_i,
   input  wire logic                      lower_i,
   output logic                           charge_o,
   output logic                           discharge_o,
   output logic [bbl_pkg::OSC_W-1:0]      count_o,
   output logic                           full_o
);
   bbl_pkg::bbl_osc_s r;
   bbl_pkg::bbl_osc_s next_r;
   logic              full;

   assign full = (r.count == bbl_pkg::OSC_W'(bbl_pkg::EXT_FULL));

   always_comb begin
      next_r = r;
      if (clr_i) begin
         next_r = '0;
      end else if (!en_i) begin
         // count held so the owner can read it after the window
         next_r.charge    = 1'b0;
         next_r.discharge = 1'b0;
      end else if (r.discharge) begin
         if (lower_i) begin
            next_r.discharge = 1'b0;
            next_r.charge    = !full;
         end
      end else if (!full) begin
         next_r.charge = 1'b1;
         if (upper_i) begin
            next_r.count     = r.count + 1'b1;
            next_r.charge    = 1'b0;
            next_r.discharge = 1'b1;
         end
      end else begin
         next_r.charge = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign charge_o    = r.charge;
   assign discharge_o = r.discharge;
   assign count_o     = r.count;
   assign full_o      = full;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   chk_osc_exclusive: assert property (!(r.charge && r.discharge))
      else $error("charge and discharge switches both on");
   chk_osc_count_step: assert property (
      (ce_i && en_i && !clr_i && r.charge && upper_i && !full)
      |=> (r.count == $past(r.count) + 1'b1) && r.discharge)
      else $error("upper crossing did not count and discharge");
endmodule : bbl_osc_cnt

/* sim/bbl_analog_model.sv */
// analog side model: extension and feedback capacitors with comparators
`timescale 1ns/1ns
module bbl_analog_model #(
   parameter int EXT_TOP = 4
) (
   input  wire logic       mclk_i,
   input  wire logic       charge_switch_i,
   input  wire logic       detect_discharge_switch_i,
   input  wire logic [9:0] fb_charge_cyc_i,
   output logic            upper_threshold_cmp_o,
   output logic            lower_threshold_cmp_o,
   output logic            fb_det_high_o,
   output logic            fb_det_low_o
);
   int v_ext = 0;
   int v_fb  = 0;
   // cap rises only through the charge switch and bleeds otherwise
   always @(posedge mclk_i) begin
      if (charge_switch_i) begin
         if (v_ext < EXT_TOP) v_ext <= v_ext + 1;
      end else if (v_ext > 0) begin
         v_ext <= v_ext - 1;
      end
      if (detect_discharge_switch_i) v_fb <= 0;
      else if (v_fb < 1023) v_fb <= v_fb + 1;
   end
   assign upper_threshold_cmp_o = (v_ext >= EXT_TOP);
   assign lower_threshold_cmp_o = (v_ext == 0);
   // charge time per cycle sets the oscillation count, discharge is fast
   assign fb_det_high_o = !detect_discharge_switch_i
                          && (v_fb >= fb_charge_cyc_i);
   assign fb_det_low_o  = detect_discharge_switch_i;
endmodule : bbl_analog_model

/* sim/blanking_and_burst_level_control_bench.sv */
// self-checking bench of the blanking and burst level block
`timescale 1ns/1ns
module blanking_and_burst_level_control_bench;
   localparam int BLANK = 200;
   localparam int DET   = 2000;
   localparam int SPIKE = 1500;
   logic mclk_i, rst_n_i = 0, ce_i = 1, gate_on_i = 0, cs_cmp_i = 0;
   logic fb_above_4v5_i = 0, fb_below_entry_i = 0, burst_exit_i = 0;
   logic wake_cmp_i = 0, sleep_cmp_i = 0, extend_mode_i = 0;
   logic supply_ok_i = 0, protect_active_i = 0;
   logic [9:0] fb_chg = 10'h000;
   logic cs_trip, csth_burst, burst_mode, bias_on, charge, discharge;
   logic ext_done, auto_rst, upper, lower, fb_hi, fb_lo, det_ff, det_sw;
   logic valid;
   logic [bbl_pkg::TRIM_W-1:0] trim;
   bbl_pkg::bbl_level_e level;
   int n_errors = 0;
   int compares = 0;

   bbl_ctrl #(.BLANK_CYC(BLANK), .DET_CYC(DET)) i_bbl_ctrl (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .gate_on_i(gate_on_i), .cs_cmp_i(cs_cmp_i), .cs_trip_o(cs_trip),
      .csth_trim_o(trim), .csth_burst_o(csth_burst),
      .fb_above_4v5_i(fb_above_4v5_i), .fb_below_entry_i(fb_below_entry_i),
      .burst_exit_i(burst_exit_i), .wake_cmp_i(wake_cmp_i),
      .sleep_cmp_i(sleep_cmp_i), .burst_mode_o(burst_mode),
      .bias_on_o(bias_on), .extend_mode_i(extend_mode_i),
      .upper_threshold_cmp_i(upper), .lower_threshold_cmp_i(lower),
      .charge_switch_o(charge), .discharge_switch_o(discharge),
      .extend_done_o(ext_done), .auto_restart_o(auto_rst),
      .supply_ok_i(supply_ok_i), .protect_active_i(protect_active_i),
      .fb_det_high_i(fb_hi), .fb_det_low_i(fb_lo),
      .detect_flipflop_o(det_ff), .detect_discharge_switch_o(det_sw),
      .burst_level_o(level), .level_valid_o(valid));

   bbl_analog_model i_bbl_analog_model (
      .mclk_i(mclk_i), .charge_switch_i(charge),
      .detect_discharge_switch_i(det_sw), .fb_charge_cyc_i(fb_chg),
      .upper_threshold_cmp_o(upper), .lower_threshold_cmp_o(lower),
      .fb_det_high_o(fb_hi), .fb_det_low_o(fb_lo));

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : tick

   task automatic give_verdict;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   task automatic bad(input string what);
      n_errors++;
      $display("BAD %0t %s", $time, what);
   endtask : bad

   task automatic timeout_hit(input string what);
      bad(what);
      give_verdict();
   endtask : timeout_hit

   task automatic check_bit(input logic got, exp, input string what);
      compares++;
      if (got !== exp) bad(what);
   endtask : check_bit

   task automatic check_level(input bbl_pkg::bbl_level_e got, exp,
                              input string what);
      compares++;
      if (got !== exp) bad(what);
   endtask : check_level

   task automatic check_count(input int got, exp, input string what);
      compares++;
      if (got != exp) bad(what);
   endtask : check_count

   task automatic do_reset;
      rst_n_i = 0;
      tick(20);
      check_bit(bias_on, 1'b1, "bias in reset");
      check_level(level, bbl_pkg::LVL_NONE, "level in reset");
      rst_n_i = 1;
   endtask : do_reset

   task automatic sc_detect(input logic [9:0] chg,
                            input bbl_pkg::bbl_level_e exp);
      int k;
      logic seen;
      fb_chg = chg;
      supply_ok_i = 0;
      protect_active_i = 1;
      do_reset();
      supply_ok_i = 1;
      tick(DET + 50);
      check_bit(valid, 1'b0, "detect while protected");
      protect_active_i = 0;
      seen = 0;
      for (k = 0; k < DET + 20 && valid !== 1'b1; k++) begin
         tick(1);
         seen = seen | det_ff;
      end
      if (k == DET + 20) timeout_hit("detect end");
      check_bit(seen, 1'b1, "detect flop");
      check_level(level, exp, "entry level");
      if (exp == bbl_pkg::LVL_NONE) begin
         fb_below_entry_i = 1;
         tick(BLANK + 10);
         check_bit(burst_mode, 1'b0, "burst at no-burst level");
         fb_below_entry_i = 0;
      end
   endtask : sc_detect

   task automatic sc_leb(input logic in_burst);
      gate_on_i = 0;
      cs_cmp_i = 1;
      tick(2);
      gate_on_i = 1;
      tick(in_burst ? 10 : 12);
      check_bit(cs_trip, 1'b0, "trip inside blanking");
      tick(3);
      check_bit(cs_trip, 1'b1, "trip after blanking");
      tick(12);
      check_bit(trim === 4'hf, 1'b1, "on-time trim");
      gate_on_i = 0;
      tick(2);
      check_bit(cs_trip, 1'b0, "trip with gate off");
      cs_cmp_i = 0;
   endtask : sc_leb

   task automatic sc_burst;
      fb_below_entry_i = 1;
      tick(BLANK - 5);
      fb_below_entry_i = 0;
      tick(1);
      fb_below_entry_i = 1;
      tick(BLANK - 5);
      check_bit(burst_mode, 1'b0, "burst too early");
      tick(10);
      check_bit(burst_mode, 1'b1, "burst entry");
      check_bit(bias_on, 1'b0, "bias off in burst");
      check_bit(csth_burst, 1'b1, "burst limit on");
      wake_cmp_i = 1;
      tick(3);
      check_bit(bias_on, 1'b1, "wake");
      wake_cmp_i = 0;
      sleep_cmp_i = 1;
      tick(3);
      check_bit(bias_on, 1'b0, "sleep");
      sleep_cmp_i = 0;
      sc_leb(1'b1);
      ce_i = 0;
      burst_exit_i = 1;
      tick(3);
      check_bit(burst_mode, 1'b1, "state frozen by enable");
      ce_i = 1;
      tick(3);
      check_bit(burst_mode, 1'b0, "burst exit");
      check_bit(csth_burst, 1'b0, "burst limit off");
      burst_exit_i = 0;
      fb_below_entry_i = 0;
   endtask : sc_burst

   task automatic sc_ol_basic;
      int k;
      extend_mode_i = 0;
      fb_above_4v5_i = 1;
      tick(BLANK + SPIKE - 5);
      check_bit(auto_rst, 1'b0, "restart too early");
      check_bit(charge, 1'b0, "charge in basic mode");
      for (k = 0; k < 30 && auto_rst !== 1'b1; k++) tick(1);
      if (k == 30) timeout_hit("basic restart");
      fb_above_4v5_i = 0;
      fb_chg = 10'h190;
      supply_ok_i = 0;
      tick(3);
      check_bit(auto_rst, 1'b0, "restart clear");
      supply_ok_i = 1;
      tick(DET + 20);
      check_bit(valid, 1'b1, "level kept");
      check_level(level, bbl_pkg::LVL_1V27, "no redetect");
   endtask : sc_ol_basic

   task automatic sc_ol_abort;
      extend_mode_i = 1;
      fb_above_4v5_i = 1;
      tick(BLANK + 30);
      check_bit(charge | discharge, 1'b1, "extension running");
      fb_above_4v5_i = 0;
      tick(3);
      check_bit(charge | discharge, 1'b0, "extension cleared");
      fb_above_4v5_i = 1;
      tick(BLANK - 5);
      check_bit(charge, 1'b0, "blanking restarted");
      fb_above_4v5_i = 0;
      tick(3);
   endtask : sc_ol_abort

   task automatic sc_ol_ext;
      int k;
      int n_up;
      logic prev;
      fb_above_4v5_i = 1;
      tick(BLANK - 5);
      check_bit(charge, 1'b0, "charge before blanking end");
      for (k = 0; k < 20 && charge !== 1'b1; k++) tick(1);
      if (k == 20) timeout_hit("charge switch");
      n_up = 0;
      prev = upper;
      for (k = 0; k < 12000 && ext_done !== 1'b1; k++) begin
         tick(1);
         check_bit(charge & discharge, 1'b0, "both switches");
         if (upper & !prev) n_up++;
         prev = upper;
      end
      if (k == 12000) timeout_hit("extension count");
      check_count(n_up, 256, "extension cycles");
      tick(2);
      check_bit(charge, 1'b0, "charge after full count");
      tick(SPIKE - 10);
      check_bit(auto_rst, 1'b0, "spike blanking");
      for (k = 0; k < 30 && auto_rst !== 1'b1; k++) tick(1);
      if (k == 30) timeout_hit("extended restart");
      fb_above_4v5_i = 0;
   endtask : sc_ol_ext

   initial begin
      #2000000;
      bad("run time limit");
      give_verdict();
   end

   initial begin
      sc_detect(10'h190, bbl_pkg::LVL_1V60);
      sc_detect(10'h03c, bbl_pkg::LVL_1V42);
      sc_detect(10'h002, bbl_pkg::LVL_NONE);
      sc_detect(10'h00a, bbl_pkg::LVL_1V27);
      sc_leb(1'b0);
      sc_burst();
      sc_ol_basic();
      sc_ol_abort();
      sc_ol_ext();
      give_verdict();
   end
endmodule : blanking_and_burst_level_control_bench
